// ===== hw/aars_defs.svh
`ifndef AARS_DEFS_SVH
`define AARS_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define AARS_OFF_CTRL_A 8'h00
`define AARS_OFF_CTRL_B 8'h04
`define AARS_OFF_CHSEL 8'h08
`define AARS_OFF_RES_LOW 8'h0c
`define AARS_OFF_RES_HIGH 8'h10
`define AARS_OFF_DID_A 8'h14
`define AARS_OFF_DID_B 8'h18
`define AARS_OFF_AMP0 8'h1c
`define AARS_OFF_AMP1 8'h20

// ----------------------------------------
// Field positions
// ----------------------------------------
`define AARS_CA_EN 7
`define AARS_CA_START 6
`define AARS_CA_AUTO 5
`define AARS_CA_DONE 4
`define AARS_CB_AMPREQ 4
`define AARS_CS_LADJ 5
`define AARS_AMP_EN 7
`define AARS_AMP_SHUNT 6
`define AARS_AMP_WMASK 8'hf3

// ----------------------------------------
// Codes and reset values
// ----------------------------------------
`define AARS_MUX_AMP0 4'hb
`define AARS_MUX_AMP1 4'hc
`define AARS_ATS_FREE 4'h0
`define AARS_ATS_PSC 2'b10
`define AARS_TS_INTERNAL 2'b00
`define AARS_RST_BYTE 8'h00
`define AARS_RST_RESULT 10'h000

// ----------------------------------------
// Timing counts, in converter clock cycles
// ----------------------------------------
`define AARS_CONV_CYCLES 8'd13
`define AARS_CONV_CYCLES_SYNC 8'd14
`define AARS_SAMPLE_CYCLES 8'd2
`define AARS_SYNC_DIV_RISE 3'h3

`endif

// ===== hw/aars_pkg.sv
package aars_pkg;
  typedef enum logic [2:0] {
    AARS_IDLE = 3'b001,
    AARS_WAIT = 3'b010,
    AARS_RUN = 3'b100
  } aars_conv_state_e;

  typedef enum logic [1:0] {
    AARS_GAIN_5 = 2'b00,
    AARS_GAIN_10 = 2'b01,
    AARS_GAIN_20 = 2'b10,
    AARS_GAIN_40 = 2'b11
  } aars_gain_e;

  typedef logic [9:0] aars_result_t;

  function automatic logic [7:0] aars_div_last(input logic [2:0] ps);
    logic [7:0] f;
    f = (ps == 3'h0) ? 8'h02 : (8'h01 << ps);
    return f - 8'h01;
  endfunction
endpackage

// ===== hw/aars_conv_if.sv
`timescale 1ns/10ps
interface aars_conv_if;
  logic [2:0] prescale;
  logic start;
  logic len14;
  logic abort;
  logic tick;
  logic busy;
  logic sampling;
  logic done;

  modport ctrl (output prescale, output start, output len14, output abort,
                input tick, input busy, input sampling, input done);
  modport seq (input prescale, input start, input len14, input abort,
               output tick, output busy, output sampling, output done);
endinterface

// ===== hw/aars_ampsync.sv
`timescale 1ns/10ps
`include "aars_defs.svh"
module aars_ampsync import aars_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic conv_tick,
  input wire logic amp_en,
  input wire logic [1:0] trig_sel,
  input wire logic [2:0] psc_event,
  output logic amp_sync_clock,
  output logic amp_event
);
  logic [2:0] div_cnt;
  logic next_event;

  // ----------------------------------------
  // Divide-by-eight sync clock and event pick
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 3'h0;
    end else if (conv_tick) begin
      div_cnt <= div_cnt + 3'h1;
    end
  end

  assign amp_sync_clock = div_cnt[2];

  always_comb begin
    if (trig_sel == `AARS_TS_INTERNAL) begin
      next_event = conv_tick && (div_cnt == `AARS_SYNC_DIV_RISE);
    end else begin
      next_event = psc_event[trig_sel - 2'h1];
    end
  end

  // Runs whether or not a conversion is under way
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp_event <= 1'b0;
    end else begin
      amp_event <= amp_en && next_event;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_int_phase;
    @(posedge pclk) disable iff (!presetn)
      amp_event && $past(trig_sel) == `AARS_TS_INTERNAL |-> $past(conv_tick) && $past(div_cnt) == `AARS_SYNC_DIV_RISE;
  endproperty
  a_int_phase: assert property (p_int_phase) else $error("internal sync event off phase");

  property p_psc_event;
    @(posedge pclk) disable iff (!presetn)
      amp_en && trig_sel == 2'b10 && psc_event[1] |=> amp_event;
  endproperty
  a_psc_event: assert property (p_psc_event) else $error("power stage event not amplified");
endmodule

// ===== hw/aars_conv.sv
`timescale 1ns/10ps
`include "aars_defs.svh"
module aars_conv import aars_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  aars_conv_if.seq cif
);
  aars_conv_state_e state;
  logic [7:0] pre_cnt;
  logic [7:0] cnt;
  logic len_q;
  logic done_q;

  // ----------------------------------------
  // Converter clock prescaler
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= 8'h00;
    end else if (pre_cnt >= aars_div_last(cif.prescale)) begin
      pre_cnt <= 8'h00;
    end else begin
      pre_cnt <= pre_cnt + 8'h01;
    end
  end

  assign cif.tick = (pre_cnt >= aars_div_last(cif.prescale));

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= AARS_IDLE;
      cnt <= 8'h00;
      len_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state)
        AARS_IDLE: begin
          if (cif.start) begin
            state <= AARS_WAIT;
            len_q <= cif.len14;
          end
        end
        AARS_WAIT: begin
          if (cif.tick) begin
            state <= AARS_RUN;
            cnt <= 8'h00;
          end
        end
        AARS_RUN: begin
          // A moving amplifier output spoils the sample, so go back and resample
          if (cif.abort && cif.sampling) begin
            state <= AARS_WAIT;
          end else if (cif.tick) begin
            if (cnt == (len_q ? `AARS_CONV_CYCLES_SYNC : `AARS_CONV_CYCLES) - 8'd1) begin
              state <= AARS_IDLE;
              done_q <= 1'b1;
            end else begin
              cnt <= cnt + 8'h01;
            end
          end
        end
        default: begin
          state <= AARS_IDLE;
        end
      endcase
    end
  end

  assign cif.busy = (state != AARS_IDLE);
  assign cif.sampling = (state == AARS_RUN) && (cnt < `AARS_SAMPLE_CYCLES);
  assign cif.done = done_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_length;
    @(posedge pclk) disable iff (!presetn)
      $rose(done_q) |-> $past(cnt) == ($past(len_q) ? 8'd13 : 8'd12);
  endproperty
  a_length: assert property (p_length) else $error("conversion length wrong");

  property p_abort;
    @(posedge pclk) disable iff (!presetn)
      state == AARS_RUN && cif.abort && cif.sampling |=> state == AARS_WAIT ##0 !done_q;
  endproperty
  a_abort: assert property (p_abort) else $error("unstable sample not restarted");
endmodule

// ===== hw/aars_top.sv
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/10ps
`include "aars_defs.svh"
module aars_top import aars_pkg::*; #(
  parameter bit IMPROVED_REV = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] power_stage_sync_event,
  input wire aars_result_t conv_result_in,
  input wire logic amp_out_changing,
  input wire logic [13:0] pin_raw_in,
  output logic [13:0] pin_port_in,
  output logic [13:0] pin_input_off_bits,
  output logic [3:0] channel_select_out,
  output logic conv_sampling,
  output logic [1:0] amp_enable,
  output logic [1:0] amp_shunt,
  output aars_gain_e amp_gain_field [2],
  output logic [1:0] amp_sync_clock,
  output logic [1:0] amp_sample
);
  aars_conv_if cif ();

  logic ctrl_en, conversion_start_bit, auto_en, done_flag, left_adjust, lock, launched;
  logic amp_start_request;
  logic [2:0] prescale;
  logic [3:0] auto_trigger_select, channel_select;
  logic [7:0] digital_input_disable_a;
  logic [5:0] digital_input_disable_b;
  logic [1:0][7:0] amp_control;
  aars_result_t result;
  logic acc, wr, rd, amp_ch, amp_idx, amp_evt_sel, amp_clk_sel, trig_evt, free_run;
  logic req_go, sw_go, sw_set, trig_set, mapped;
  logic [7:0] result_high_byte, result_low_byte;
  logic [1:0] amp_evt;

  function automatic logic hit(input logic strobe, input logic [7:0] a, input logic [7:0] off);
    return strobe && (a == off);
  endfunction

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign pready = 1'b1;
  assign mapped = (paddr <= `AARS_OFF_AMP1) && (paddr[1:0] == 2'b00);
  assign pslverr = acc && !mapped;

  // ----------------------------------------
  // Channel and start decisions
  // ----------------------------------------
  assign amp_ch = (channel_select == `AARS_MUX_AMP0) || (channel_select == `AARS_MUX_AMP1);
  assign amp_idx = (channel_select == `AARS_MUX_AMP1);
  assign amp_evt_sel = amp_evt[amp_idx];
  assign amp_clk_sel = amp_sync_clock[amp_idx] && (amp_control[amp_idx][1:0] == `AARS_TS_INTERNAL);
  // Trigger decode only knows the power stage sources
  assign trig_evt = auto_en && (auto_trigger_select[3:2] == `AARS_ATS_PSC) &&
                    (auto_trigger_select[1:0] != 2'b11) && power_stage_sync_event[auto_trigger_select[1:0]];
  // Free running restart is withheld on amplified channels
  assign free_run = auto_en && (auto_trigger_select == `AARS_ATS_FREE) && !amp_ch;
  assign req_go = !IMPROVED_REV && amp_start_request && amp_ch && amp_evt_sel &&
                  !conversion_start_bit && ctrl_en;
  // Original revision holds amplified starts for the amplifier clock event
  assign sw_go = conversion_start_bit && !launched && ctrl_en &&
                 (IMPROVED_REV || !amp_ch || amp_evt_sel);
  // A pending amplified request blocks software start writes on other channels
  assign sw_set = hit(wr, paddr, `AARS_OFF_CTRL_A) && pwdata[`AARS_CA_START] &&
                  !(amp_start_request && !amp_ch);
  assign trig_set = trig_evt && !conversion_start_bit;

  assign cif.start = req_go || sw_go;
  assign cif.len14 = amp_ch && amp_clk_sel && !auto_en;
  assign cif.abort = IMPROVED_REV && amp_ch && amp_out_changing;
  assign cif.prescale = prescale;
  assign conv_sampling = cif.sampling;

  aars_conv u_conv (
    .pclk(pclk),
    .presetn(presetn),
    .cif(cif)
  );

  for (genvar i = 0; i < 2; i++) begin : g_amp
    aars_ampsync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .conv_tick(cif.tick),
      .amp_en(amp_control[i][`AARS_AMP_EN]),
      .trig_sel(amp_control[i][1:0]),
      .psc_event(power_stage_sync_event),
      .amp_sync_clock(amp_sync_clock[i]),
      .amp_event(amp_evt[i])
    );
    assign amp_enable[i] = amp_control[i][`AARS_AMP_EN];
    assign amp_shunt[i] = amp_control[i][`AARS_AMP_SHUNT];
    assign amp_gain_field[i] = aars_gain_e'(amp_control[i][5:4]);
  end
  assign amp_sample = amp_evt;

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en <= 1'b0;
      auto_en <= 1'b0;
      prescale <= 3'h0;
      auto_trigger_select <= 4'h0;
      channel_select <= 4'h0;
      left_adjust <= 1'b0;
      amp_control <= '0;
      digital_input_disable_a <= `AARS_RST_BYTE;
      digital_input_disable_b <= 6'h00;
    end else begin
      if (hit(wr, paddr, `AARS_OFF_CTRL_A)) begin
        ctrl_en <= pwdata[`AARS_CA_EN];
        auto_en <= pwdata[`AARS_CA_AUTO];
        prescale <= pwdata[2:0];
      end
      if (hit(wr, paddr, `AARS_OFF_CTRL_B)) begin
        auto_trigger_select <= pwdata[3:0];
      end
      // A channel select write during a conversion is dropped, not held for the conversion end
      if (hit(wr, paddr, `AARS_OFF_CHSEL) && !cif.busy) begin
        channel_select <= pwdata[3:0];
        left_adjust <= pwdata[`AARS_CS_LADJ];
      end
      if (hit(wr, paddr, `AARS_OFF_DID_A)) begin
        digital_input_disable_a <= pwdata[7:0];
      end
      if (hit(wr, paddr, `AARS_OFF_DID_B)) begin
        digital_input_disable_b <= pwdata[5:0];
      end
      if (hit(wr, paddr, `AARS_OFF_AMP0)) begin
        amp_control[0] <= pwdata[7:0] & `AARS_AMP_WMASK;
      end
      if (hit(wr, paddr, `AARS_OFF_AMP1)) begin
        amp_control[1] <= pwdata[7:0] & `AARS_AMP_WMASK;
      end
    end
  end

  // ----------------------------------------
  // Start bit, request bit and launch tracking
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_start_bit <= 1'b0;
    end else if (req_go || sw_set || trig_set) begin
      conversion_start_bit <= 1'b1;
    end else if (cif.done && !free_run) begin
      conversion_start_bit <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      launched <= 1'b0;
    end else if (cif.done) begin
      launched <= 1'b0;
    end else if (cif.start) begin
      launched <= 1'b1;
    end
  end

  // Software write wins over the hardware clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp_start_request <= 1'b0;
    end else if (hit(wr, paddr, `AARS_OFF_CTRL_B)) begin
      amp_start_request <= pwdata[`AARS_CB_AMPREQ] && !IMPROVED_REV;
    end else if (req_go) begin
      amp_start_request <= 1'b0;
    end
  end

  // Set by a finished conversion, cleared by writing one; a set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_flag <= 1'b0;
    end else if (cif.done) begin
      done_flag <= 1'b1;
    end else if (hit(wr, paddr, `AARS_OFF_CTRL_A) && pwdata[`AARS_CA_DONE]) begin
      done_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // Result capture and read-order lock
  // ----------------------------------------
  // A result finishing while locked is dropped, never half written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result <= `AARS_RST_RESULT;
    end else if (cif.done && !lock) begin
      result <= conv_result_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock <= 1'b0;
    end else if (hit(rd, paddr, `AARS_OFF_RES_HIGH)) begin
      lock <= 1'b0;
    end else if (hit(rd, paddr, `AARS_OFF_RES_LOW)) begin
      lock <= 1'b1;
    end
  end

  assign result_high_byte = left_adjust ? result[9:2] : {6'h00, result[9:8]};
  assign result_low_byte = left_adjust ? {result[1:0], 6'h00} : result[7:0];

  // ----------------------------------------
  // Pin input gating
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_port_in <= 14'h0000;
    end else begin
      pin_port_in <= pin_raw_in & ~{digital_input_disable_b, digital_input_disable_a};
    end
  end
  assign pin_input_off_bits = {digital_input_disable_b, digital_input_disable_a};
  assign channel_select_out = channel_select;

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd) begin
      case (paddr)
        `AARS_OFF_CTRL_A: prdata[7:0] = {ctrl_en, conversion_start_bit, auto_en, done_flag, 1'b0, prescale};
        `AARS_OFF_CTRL_B: prdata[7:0] = {3'h0, amp_start_request, auto_trigger_select};
        `AARS_OFF_CHSEL: prdata[7:0] = {2'h0, left_adjust, 1'b0, channel_select};
        `AARS_OFF_RES_LOW: prdata[7:0] = result_low_byte;
        `AARS_OFF_RES_HIGH: prdata[7:0] = result_high_byte;
        `AARS_OFF_DID_A: prdata[7:0] = digital_input_disable_a;
        `AARS_OFF_DID_B: prdata[7:0] = {2'h0, digital_input_disable_b};
        `AARS_OFF_AMP0: prdata[7:0] = amp_control[0];
        `AARS_OFF_AMP1: prdata[7:0] = amp_control[1];
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_capture;
    @(posedge pclk) disable iff (!presetn)
      cif.done && !lock |=> result == $past(conv_result_in);
  endproperty
  a_capture: assert property (p_capture) else $error("result not captured");

  property p_lock_hold;
    @(posedge pclk) disable iff (!presetn)
      lock && !hit(rd, paddr, `AARS_OFF_RES_HIGH) |=> $stable(result);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("locked result changed");

  property p_unlock;
    @(posedge pclk) disable iff (!presetn)
      hit(rd, paddr, `AARS_OFF_RES_HIGH) |=> !lock;
  endproperty
  a_unlock: assert property (p_unlock) else $error("high read left lock set");

  property p_left_adj;
    @(posedge pclk) disable iff (!presetn)
      hit(rd, paddr, `AARS_OFF_RES_HIGH) && left_adjust |-> prdata == {24'h0, result[9:2]};
  endproperty
  a_left_adj: assert property (p_left_adj) else $error("left adjusted high byte wrong");

  property p_right_adj;
    @(posedge pclk) disable iff (!presetn)
      hit(rd, paddr, `AARS_OFF_RES_HIGH) && !left_adjust |-> prdata[7:2] == 6'h00;
  endproperty
  a_right_adj: assert property (p_right_adj) else $error("right adjusted high byte not zero above");

  property p_pin_off;
    @(posedge pclk) disable iff (!presetn)
      ##1 (pin_port_in & $past(pin_input_off_bits)) == 14'h0000;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("disabled pin read non-zero");

  property p_no_restart;
    @(posedge pclk) disable iff (!presetn)
      cif.busy |-> !cif.start;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("start while converting");

  property p_req_launch;
    @(posedge pclk) disable iff (!presetn)
      req_go && !hit(wr, paddr, `AARS_OFF_CTRL_B) |-> cif.start ##1 (conversion_start_bit && !amp_start_request);
  endproperty
  a_req_launch: assert property (p_req_launch) else $error("request not launched on amp event");

  property p_immediate;
    @(posedge pclk) disable iff (!presetn)
      IMPROVED_REV && conversion_start_bit && !launched && ctrl_en && !cif.busy |-> cif.start;
  endproperty
  a_immediate: assert property (p_immediate) else $error("improved start delayed");

  c_locked_drop: cover property (@(posedge pclk) disable iff (!presetn) cif.done && lock);
  c_amp_start: cover property (@(posedge pclk) disable iff (!presetn) cif.start && amp_ch);
  c_free_run: cover property (@(posedge pclk) disable iff (!presetn) cif.done && free_run);
endmodule

// ===== verif/aars_analog_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// Analog core and power stage stand-in
// ----------------------------------------
module aars_analog_model import aars_pkg::*; #(
  parameter int EVT_PERIOD = 1000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire aars_result_t res,
  input wire logic conv_sampling,
  output aars_result_t conv_result_in,
  output logic amp_out_changing,
  output logic [2:0] power_stage_sync_event
);
  int cnt;
  // Events kept far apart so sync clock and trigger rate stay legal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      power_stage_sync_event <= 3'h0;
    end else begin
      cnt <= (cnt == EVT_PERIOD - 1) ? 0 : cnt + 1;
      power_stage_sync_event <= (cnt == 0) ? 3'h7 : 3'h0;
    end
  end
  // Core output is not settled while sampling, so show the inverse then
  assign conv_result_in = conv_sampling ? ~res : res;
  assign amp_out_changing = 1'b0;
endmodule

// ===== verif/amplified_adc_result_sync_bench.sv
`timescale 1ns/10ps
`include "aars_defs.svh"
module amplified_adc_result_sync_bench import aars_pkg::*;;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err, aoc, smp;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, m, seed = 32'd94652;
  logic [13:0] raw = 14'h0, port_in, off;
  aars_result_t res = 10'h000, cres, r;
  logic [2:0] power_stage_ctrl;
  logic [3:0] cs;
  logic [1:0] aen, ash, sclk, asmp;
  aars_gain_e gain [2];
  int fails = 0, samples_checked = 0, n, g;
  aars_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_stage_sync_event(power_stage_ctrl), .conv_result_in(cres), .amp_out_changing(aoc), .pin_raw_in(raw),
    .pin_port_in(port_in), .pin_input_off_bits(off), .channel_select_out(cs), .conv_sampling(smp),
    .amp_enable(aen), .amp_shunt(ash), .amp_gain_field(gain), .amp_sync_clock(sclk), .amp_sample(asmp));
  aars_analog_model u_model (.pclk(pclk), .presetn(presetn), .res(res), .conv_sampling(smp),
    .conv_result_in(cres), .amp_out_changing(aoc), .power_stage_sync_event(power_stage_ctrl));
  initial begin
    forever #2 pclk = ~pclk;
  end
  function logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function logic [31:0] xb(input aars_result_t v, input logic la, input logic hi);
    if (la) return hi ? {24'h0, v[9:2]} : {24'h0, v[1:0], 6'h00};
    return hi ? {30'h0, v[9:8]} : {24'h0, v[7:0]};
  endfunction
  task summarize;
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] e, input logic [31:0] v);
    samples_checked++;
    if (v !== e) begin
      fails++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, v);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin fails++; summarize(); end
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Launch one conversion and wait for the done flag, then clear it
  task conv(input logic [3:0] ch, input logic la, input aars_result_t v);
    res <= v;
    apb(1'b1, `AARS_OFF_CHSEL, {26'h0, la, 1'b0, ch});
    apb(1'b1, (ch == `AARS_MUX_AMP0) ? `AARS_OFF_CTRL_B : `AARS_OFF_CTRL_A, (ch == `AARS_MUX_AMP0) ? 32'h10 : 32'hc7);
    waitdone();
  endtask
  // Poll the done flag, then clear it; the clear write also leaves auto triggering off
  task waitdone;
    n = 0;
    do begin apb(1'b0, `AARS_OFF_CTRL_A, 32'h0); n++; end while (rd[4] !== 1'b1 && n < 2000);
    if (rd[4] !== 1'b1) begin fails++; summarize(); end
    apb(1'b1, `AARS_OFF_CTRL_A, 32'h97);
  endtask
  task rdres(input aars_result_t v, input logic la);
    apb(1'b0, `AARS_OFF_RES_LOW, 32'h0);
    chk(xb(v, la, 1'b0), rd);
    apb(1'b0, `AARS_OFF_RES_HIGH, 32'h0);
    chk(xb(v, la, 1'b1), rd);
  endtask
  task gap(output int gl);
    int k;
    k = 0;
    do begin @(posedge pclk); k++; end while (asmp[0] !== 1'b1 && k < 2000);
    gl = 0;
    do begin @(posedge pclk); gl++; end while (asmp[0] !== 1'b1 && gl < 2000);
  endtask
  initial begin
    repeat (100000) @(posedge pclk);
    fails++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, `AARS_OFF_RES_LOW + 8'(4 * i), 32'h0);
      chk(32'h0, rd);
    end
    apb(1'b1, 8'h24, 32'hff);
    chk(32'h1, {31'h0, err});
    // Masks: random plus the all-ones corner
    for (int i = 0; i < 3; i++) begin
      m = (i == 0) ? 32'h3fff : rnd();
      apb(1'b1, `AARS_OFF_DID_A, {24'h0, m[7:0]});
      apb(1'b1, `AARS_OFF_DID_B, {26'h0, m[13:8]});
      apb(1'b0, `AARS_OFF_DID_B, 32'h0);
      chk({26'h0, m[13:8]}, rd);
      raw <= 14'(rnd());
      repeat (2) @(posedge pclk);
      chk({18'h0, m[13:0]}, {18'h0, off});
      chk({18'h0, raw & ~m[13:0]}, {18'h0, port_in});
    end
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `AARS_OFF_AMP1, 32'(i << 4) | 32'hc3);
      @(posedge pclk);
      chk(32'(i), 32'(gain[1]));
      chk(32'h3, {30'h0, aen[1], ash[1]});
    end
    // Slowest prescale keeps the amplifier sync clock at or below its limit
    apb(1'b1, `AARS_OFF_CTRL_A, 32'h87);
    for (int t = 0; t < 3; t++) begin
      apb(1'b1, `AARS_OFF_AMP0, 32'h80 | 32'(t));
      gap(g);
      gap(g);
      chk(t ? 32'd1000 : 32'd1024, 32'(g));
    end
    apb(1'b1, `AARS_OFF_AMP0, 32'h80);
    for (int i = 0; i < 4; i++) begin
      r = 10'(rnd());
      conv(i[0] ? `AARS_MUX_AMP0 : 4'h0, i[1], r);
      rdres(r, i[1]);
    end
    // Result finishing while the low byte holds the lock is dropped
    r = 10'(rnd());
    conv(4'h0, 1'b0, r);
    apb(1'b0, `AARS_OFF_RES_LOW, 32'h0);
    chk(xb(r, 1'b0, 1'b0), rd);
    conv(4'h0, 1'b0, ~r);
    apb(1'b0, `AARS_OFF_RES_HIGH, 32'h0);
    chk(xb(r, 1'b0, 1'b1), rd);
    conv(4'h0, 1'b0, ~r);
    rdres(~r, 1'b0);
    // Power stage event 0 auto-triggers the amplified channel
    r = 10'(rnd());
    res <= r;
    apb(1'b1, `AARS_OFF_CHSEL, {28'h0, `AARS_MUX_AMP0});
    apb(1'b1, `AARS_OFF_CTRL_B, 32'h08);
    apb(1'b1, `AARS_OFF_CTRL_A, 32'ha7);
    waitdone();
    rdres(r, 1'b0);
    summarize();
  end
endmodule
